/* File: hw/reg_bank.sv */
`default_nettype none

module reg_bank
  import rtc_port_pkg::*;
#(
  parameter int DEPTH = NUM_REGS,
  parameter int WIDTH = 8,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0]            rdata;
  } bank_t;

  bank_t st;
  bank_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // read returns the old word on a same-address write; the port avoids that case
  always_comb begin
    next_st = st;
    if (we && (int'(waddr) < DEPTH)) begin
      next_st.cells[waddr] = wdata;
    end
    next_st.rdata = (int'(raddr) < DEPTH) ? st.cells[raddr] : '0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;

endmodule // reg_bank

`default_nettype wire

/* File: hw/rtc_port_pkg.sv */
`default_nettype none

package rtc_port_pkg;

  localparam int          NUM_REGS      = 10;
  localparam logic [7:0]  DEV_ADDR_BYTE = 8'hD0;
  localparam logic [3:0]  REG_SECONDS   = 4'h0;
  localparam logic [3:0]  REG_MINUTES   = 4'h1;
  localparam logic [3:0]  REG_CENT_HRS  = 4'h2;
  localparam logic [3:0]  REG_WEEKDAY   = 4'h3;
  localparam logic [3:0]  REG_DAY_MONTH = 4'h4;
  localparam logic [3:0]  REG_MONTH     = 4'h5;
  localparam logic [3:0]  REG_YEAR      = 4'h6;
  localparam logic [3:0]  REG_TRIM_CTRL = 4'h7;
  localparam logic [3:0]  REG_SOUND     = 4'h8;
  localparam logic [3:0]  REG_SECONDARY = 4'h9;
  localparam logic [3:0]  LAST_REG      = REG_SECONDARY;
  localparam logic [3:0]  PTR_RESET     = 4'h0;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT   = 4'h7;

  typedef enum logic [2:0] {IDLE, RX_BYTE, RX_ACK, LOAD_TX, TX_BYTE, TX_ACK} port_state_t;
  typedef enum logic [1:0] {PH_DEV, PH_WADDR, PH_DATA} byte_phase_t;

  // sequential access wraps past the last register
  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    return (p >= LAST_REG) ? PTR_RESET : p + 4'h1;
  endfunction

endpackage

`default_nettype wire

/* File: hw/rtc_serial_register_port.sv */
`default_nettype none

module rtc_serial_register_port
  import rtc_port_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       below_pfd,
  input  wire logic       above_so,
  output logic            bus_blocked,
  output logic            update_valid,
  input  wire logic       update_ready,
  output logic      [3:0] update_addr,
  output logic      [7:0] update_data
);

  typedef struct packed {
    logic             scl_m;
    logic             scl_s;
    logic             scl_p;
    logic             sda_m;
    logic             sda_s;
    logic             sda_p;
    logic             pfd_m;
    logic             pfd_s;
    logic             so_m;
    logic             so_s;
    logic             blocked;
    port_state_t      state;
    byte_phase_t      phase;
    logic [3:0]       bitcnt;
    logic [7:0]       shreg;
    logic             rw;
    logic             acked;
    logic             rd_wait;
    logic [3:0]       pointer;
    logic             sda_oe;
    logic             scl_oe;
    logic             low_lvl;
    logic [1:0]       fifo_cnt;
    logic [1:0][3:0]  fifo_addr;
    logic [1:0][7:0]  fifo_data;
    logic             upd_valid;
  } port_t;

  port_t      st;
  port_t      next_st;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       pop;
  logic       push;
  logic       buf_ready;
  logic [1:0] cnt_after;
  logic [7:0] rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // line events, taken only from second-stage and later samples
  assign scl_rise  = st.scl_s & ~st.scl_p;
  assign scl_fall  = ~st.scl_s & st.scl_p;
  assign start_det = st.scl_s & st.scl_p & st.sda_p & ~st.sda_s;
  assign stop_det  = st.scl_s & st.scl_p & ~st.sda_p & st.sda_s;
  assign pop       = st.upd_valid & update_ready;
  assign buf_ready = (st.fifo_cnt != 2'h2);
  assign cnt_after = st.fifo_cnt - {1'b0, pop};

  reg_bank #(
    .DEPTH (NUM_REGS),
    .WIDTH (8),
    .AW    (4)
  ) u_bank (
    .clk   (clk),
    .rst   (rst),
    .we    (pop),
    .waddr (st.fifo_addr[0]),
    .wdata (st.fifo_data[0]),
    .raddr (st.pointer),
    .rdata (rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st       = st;
    push          = 1'b0;
    next_st.scl_m = scl_i;
    next_st.scl_s = st.scl_m;
    next_st.scl_p = st.scl_s;
    next_st.sda_m = sda_i;
    next_st.sda_s = st.sda_m;
    next_st.sda_p = st.sda_s;
    next_st.pfd_m = below_pfd;
    next_st.pfd_s = st.pfd_m;
    next_st.so_m  = above_so;
    next_st.so_s  = st.so_m;
    if (st.pfd_s) begin
      next_st.blocked = 1'b1;
    end else if (st.so_s) begin
      next_st.blocked = 1'b0;
    end
    case (st.state)
      IDLE: begin
        next_st.sda_oe = 1'b0;
        next_st.scl_oe = 1'b0;
      end
      RX_BYTE: begin
        if (scl_rise && (st.bitcnt != BITS_PER_BYTE)) begin
          next_st.shreg  = {st.shreg[6:0], st.sda_s};
          next_st.bitcnt = st.bitcnt + 4'h1;
        end else if ((st.bitcnt == BITS_PER_BYTE) && !st.scl_s) begin
          case (st.phase)
            PH_DEV: begin
              if (st.shreg[7:1] == DEV_ADDR_BYTE[7:1]) begin
                next_st.rw     = st.shreg[0];
                next_st.sda_oe = 1'b1;
                next_st.state  = RX_ACK;
              end else begin
                next_st.state = IDLE;
              end
            end
            PH_WADDR: begin
              // an out-of-map word address falls back to the first register
              next_st.pointer = (st.shreg <= {4'h0, LAST_REG}) ? st.shreg[3:0]
                                                               : PTR_RESET;
              next_st.sda_oe  = 1'b1;
              next_st.state   = RX_ACK;
            end
            default: begin
              if (buf_ready) begin
                push            = 1'b1;
                next_st.pointer = ptr_inc(st.pointer);
                next_st.sda_oe  = 1'b1;
                next_st.scl_oe  = 1'b0;
                next_st.state   = RX_ACK;
              end else begin
                // stretch the clock rather than drop a written byte
                next_st.scl_oe = 1'b1;
              end
            end
          endcase
        end
      end
      RX_ACK: begin
        if (scl_fall) begin
          next_st.sda_oe = 1'b0;
          next_st.bitcnt = 4'h0;
          if ((st.phase == PH_DEV) && st.rw) begin
            next_st.state   = LOAD_TX;
            next_st.scl_oe  = 1'b1;
            next_st.rd_wait = 1'b0;
          end else begin
            next_st.phase = (st.phase == PH_DEV) ? PH_WADDR : PH_DATA;
            next_st.state = RX_BYTE;
          end
        end
      end
      LOAD_TX: begin
        // wait for buffered writes to land so a read sees them
        if (!st.rd_wait) begin
          next_st.rd_wait = (st.fifo_cnt == 2'h0);
        end else begin
          next_st.shreg   = rdata;
          next_st.sda_oe  = ~rdata[7];
          next_st.scl_oe  = 1'b0;
          next_st.rd_wait = 1'b0;
          next_st.bitcnt  = 4'h0;
          next_st.state   = TX_BYTE;
        end
      end
      TX_BYTE: begin
        if (scl_fall) begin
          if (st.bitcnt == LAST_TX_BIT) begin
            next_st.sda_oe = 1'b0;
            next_st.acked  = 1'b0;
            next_st.state  = TX_ACK;
          end else begin
            next_st.shreg  = {st.shreg[6:0], 1'b0};
            next_st.sda_oe = ~st.shreg[6];
            next_st.bitcnt = st.bitcnt + 4'h1;
          end
        end
      end
      TX_ACK: begin
        if (scl_rise) begin
          next_st.acked = ~st.sda_s;
          if (!st.sda_s) begin
            next_st.pointer = ptr_inc(st.pointer);
          end
        end else if (scl_fall) begin
          next_st.state   = st.acked ? LOAD_TX : IDLE;
          next_st.scl_oe  = st.acked;
          next_st.rd_wait = 1'b0;
        end
      end
      default: begin
        next_st.state = IDLE;
      end
    endcase
    if (start_det && !st.blocked) begin
      next_st.state  = RX_BYTE;
      next_st.phase  = PH_DEV;
      next_st.bitcnt = 4'h0;
      next_st.sda_oe = 1'b0;
      next_st.scl_oe = 1'b0;
    end else if (stop_det || st.blocked) begin
      next_st.state  = IDLE;
      next_st.sda_oe = 1'b0;
      next_st.scl_oe = 1'b0;
    end
    if (st.pfd_s) begin
      next_st.state   = IDLE;
      next_st.pointer = PTR_RESET;
      next_st.sda_oe  = 1'b0;
      next_st.scl_oe  = 1'b0;
      next_st.bitcnt  = 4'h0;
    end
    // two-entry write buffer toward the register bank
    if (pop) begin
      next_st.fifo_addr[0] = st.fifo_addr[1];
      next_st.fifo_data[0] = st.fifo_data[1];
    end
    if (push) begin
      next_st.fifo_addr[cnt_after[0]] = st.pointer;
      next_st.fifo_data[cnt_after[0]] = st.shreg;
    end
    next_st.fifo_cnt  = cnt_after + {1'b0, push};
    next_st.upd_valid = (next_st.fifo_cnt != 2'h0);
    next_st.low_lvl   = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign scl_o        = st.low_lvl;
  assign scl_oe       = st.scl_oe;
  assign sda_o        = st.low_lvl;
  assign sda_oe       = st.sda_oe;
  assign bus_blocked  = st.blocked;
  assign update_valid = st.upd_valid;
  assign update_addr  = st.fifo_addr[0];
  assign update_data  = st.fifo_data[0];

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic byte_done;
  assign byte_done = (st.state == RX_BYTE) && (st.bitcnt == BITS_PER_BYTE) && !st.scl_s
                     && !start_det && !stop_det && !st.blocked && !st.pfd_s;

  addr_ack_a: assert property (
    byte_done && (st.phase == PH_DEV) && (st.shreg[7:1] == DEV_ADDR_BYTE[7:1])
    |=> (st.state == RX_ACK) && st.sda_oe)
    else $error("matching address not acknowledged");

  addr_nack_a: assert property (
    byte_done && (st.phase == PH_DEV) && (st.shreg[7:1] != DEV_ADDR_BYTE[7:1])
    |=> (st.state == IDLE) && !st.sda_oe)
    else $error("foreign address acknowledged");

  write_inc_a: assert property (
    byte_done && (st.phase == PH_DATA) && buf_ready
    |=> (st.pointer == ptr_inc($past(st.pointer))) && (st.fifo_cnt != 2'h0))
    else $error("pointer not advanced after written byte");

  pfd_abort_a: assert property (
    st.pfd_s |=> (st.state == IDLE) && (st.pointer == PTR_RESET) && !st.sda_oe && st.blocked)
    else $error("power fail did not abort access");

  ignore_start_a: assert property (
    st.blocked && start_det |=> (st.state == IDLE) [*2])
    else $error("start recognised while blocked");

  start_seen_a: assert property (
    start_det && !st.blocked && !st.pfd_s |=> (st.state == RX_BYTE) && (st.bitcnt == 4'h0))
    else $error("start not detected");

  stop_seen_a: assert property (
    stop_det && !start_det |=> (st.state == IDLE) && !st.sda_oe && !st.scl_oe)
    else $error("stop did not end transfer");

  ack_hold_a: assert property (
    (st.state == RX_ACK) && st.scl_s |-> st.sda_oe)
    else $error("acknowledge released during clock high");

  rd_nack_a: assert property (
    (st.state == TX_ACK) && scl_rise && st.sda_s && !st.blocked && !st.pfd_s
    |=> $stable(st.pointer) && !st.sda_oe && !st.acked)
    else $error("pointer moved or line held on missing acknowledge");

  tx_steady_a: assert property (
    (st.state == TX_BYTE) && st.scl_s && $past(st.scl_s) && ($past(st.state) == TX_BYTE)
    |-> $stable(st.sda_oe))
    else $error("data changed while clock high");

  write_cov: cover property (byte_done && (st.phase == PH_DATA) && buf_ready);
  read_cov: cover property ((st.state == TX_ACK) && scl_rise && !st.sda_s);
  nack_cov: cover property (byte_done && (st.phase == PH_DEV)
                            && (st.shreg[7:1] != DEV_ADDR_BYTE[7:1]));
  stretch_cov: cover property (byte_done && (st.phase == PH_DATA) && !buf_ready);

endmodule // rtc_serial_register_port

`default_nettype wire

/* File: verif/i2c_master_model.sv */
`default_nettype none

module i2c_master_model (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low,
  output logic      hung
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hung    = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // every change lands 1 ns after an edge
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // the device may stretch; bounded so a stuck line cannot hang the run
  task automatic rise();
    int k;
    k = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && k < 3000) begin
      pause(1);
      k++;
    end
    if (k == 3000) hung = 1'b1;
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    pause(4);
    rise();
    pause(4);
    r = sda;
    pause(4);
    scl_low = 1'b1;
    pause(4);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic start();
    sda_low = 1'b0;
    pause(4);
    rise();
    pause(4);
    sda_low = 1'b1;
    pause(8);
    scl_low = 1'b1;
    pause(4);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    pause(4);
    rise();
    pause(4);
    sda_low = 1'b0;
    pause(8);
  endtask

  task automatic send(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, nak);
  endtask

  task automatic recv(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nak, r);
  endtask
endmodule // i2c_master_model

`default_nettype wire

/* File: verif/tb_rtc_serial_register_port.sv */
`default_nettype none

module tb_rtc_serial_register_port;
  timeunit 1ns;
  timeprecision 100ps;
  import rtc_port_pkg::*;

  logic        clk, rst, below_pfd, above_so, update_ready;
  logic        scl, sda, scl_o, scl_oe, sda_o, sda_oe, bus_blocked, update_valid;
  logic        scl_low, sda_low, hung, n;
  logic [3:0]  update_addr;
  logic [7:0]  update_data, d;
  logic [11:0] upd[$];
  logic [11:0] wexp[3] = '{12'h85A, 12'h9C3, 12'h081};
  int          fails, samples_checked;

  // pull-ups: a released line reads high
  assign scl = ~(scl_low | (scl_oe & ~scl_o));
  assign sda = ~(sda_low | (sda_oe & ~sda_o));

  rtc_serial_register_port uut (
    .clk(clk), .rst(rst), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .below_pfd(below_pfd),
    .above_so(above_so), .bus_blocked(bus_blocked), .update_valid(update_valid),
    .update_ready(update_ready), .update_addr(update_addr), .update_data(update_data)
  );

  i2c_master_model m (
    .clk(clk), .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low), .hung(hung)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (update_valid === 1'b1 && update_ready === 1'b1) upd.push_back({update_addr, update_data});
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic exp_nak);
    m.send(b, n);
    check("ack", {7'h00, n}, {7'h00, exp_nak});
  endtask

  task automatic get(input logic nak, input logic [7:0] exp);
    m.recv(nak, d);
    check("rdata", d, exp);
  endtask

  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // generous: the whole sequence needs a little under a tenth of this
  initial begin
    #300000;
    fails++;
    give_verdict();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    below_pfd = 1'b0;
    above_so = 1'b1;
    update_ready = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    m.start();
    put(DEV_ADDR_BYTE | 8'h01, 1'b0);
    get(1'b1, REG_RESET);
    m.stop();
    // receiver stalls: third byte must wait on a stretched clock
    update_ready = 1'b0;
    fork
      begin
        m.start();
        put(DEV_ADDR_BYTE, 1'b0);
        put(8'h08, 1'b0);
        put(8'h5A, 1'b0);
        put(8'hC3, 1'b0);
        put(8'h81, 1'b0);
        m.stop();
      end
      begin
        m.pause(1200);
        check("stretch", {7'h00, scl_oe}, 8'h01);
        check("queued", 8'(upd.size()), 8'h00);
        update_ready = 1'b1;
      end
    join
    check("count", 8'(upd.size()), 8'h03);
    for (int i = 0; i < 3; i++) begin
      check("uaddr", {4'h0, upd[i][11:8]}, {4'h0, wexp[i][11:8]});
      check("udata", upd[i][7:0], wexp[i][7:0]);
    end
    m.start();
    put(DEV_ADDR_BYTE, 1'b0);
    put(8'h08, 1'b0);
    m.start();
    put(DEV_ADDR_BYTE | 8'h01, 1'b0);
    get(1'b0, 8'h5A);
    get(1'b0, 8'hC3);
    get(1'b1, 8'h81);
    // long enough for a wrongly reloaded next byte to show on the line
    m.pause(4);
    check("release", {7'h00, sda_oe}, 8'h00);
    m.stop();
    // no acknowledge on the last read: pointer held on register 0
    m.start();
    put(DEV_ADDR_BYTE | 8'h01, 1'b0);
    get(1'b0, 8'h81);
    get(1'b1, REG_RESET);
    m.stop();
    // word address past the map falls back to the first register
    m.start();
    put(DEV_ADDR_BYTE, 1'b0);
    put(8'h0F, 1'b0);
    m.start();
    put(DEV_ADDR_BYTE | 8'h01, 1'b0);
    get(1'b1, 8'h81);
    m.stop();
    m.start();
    put(8'hA0, 1'b1);
    put(8'h3C, 1'b1);
    m.stop();
    // supply drop in mid-byte after the pointer was set to 5
    m.start();
    put(DEV_ADDR_BYTE, 1'b0);
    put(8'h05, 1'b0);
    fork
      m.send(8'h77, n);
      begin
        m.pause(30);
        below_pfd = 1'b1;
        above_so = 1'b0;
      end
    join
    m.stop();
    m.pause(4);
    check("blocked", {7'h00, bus_blocked}, 8'h01);
    m.start();
    put(DEV_ADDR_BYTE, 1'b1);
    m.stop();
    below_pfd = 1'b0;
    above_so = 1'b1;
    m.pause(10);
    check("unblocked", {7'h00, bus_blocked}, 8'h00);
    m.start();
    put(DEV_ADDR_BYTE | 8'h01, 1'b0);
    get(1'b1, 8'h81);
    m.stop();
    check("count", 8'(upd.size()), 8'h03);
    check("hung", {7'h00, hung}, 8'h00);
    give_verdict();
  end
endmodule // tb_rtc_serial_register_port

`default_nettype wire
